/* File: verilog/spicmd_pkg.sv */
// Constants, types and helpers for the serial memory command engine.
// Assumes the engine is clocked well above the serial clock rate.
`default_nettype none
package spicmd_pkg;
  // Opcodes
  localparam logic [7:0] OP_SET_WL  = 8'h06;
  localparam logic [7:0] OP_CLR_WL  = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_MEM_RD  = 8'h03;
  localparam logic [7:0] OP_MEM_WR  = 8'h02;
  localparam logic [7:0] OP_COMP_RD = 8'h13;
  localparam logic [7:0] OP_COMP_WR = 8'h12;
  // Array and companion address space
  localparam int          MEM_AW    = 15;
  localparam logic [14:0] MEM_LAST  = 15'h7fff;
  localparam logic [7:0]  COMP_LAST = 8'h1d;
  // Block-protect range starts
  localparam logic [14:0] PROT_QTR  = 15'h6000;
  localparam logic [14:0] PROT_HALF = 15'h4000;
  // Status register layout
  localparam int         ST_LATCH_BIT = 1;
  localparam int         ST_BP_LO   = 2;
  localparam int         ST_BP_HI   = 3;
  localparam logic [7:0] ST_FIXED   = 8'h40;
  localparam logic [1:0] BP_FACTORY = 2'h0;
  // Reset values
  localparam logic       LATCH_RST  = 1'b0;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_OPC    = 5'h02,
    ST_ADDR   = 5'h04,
    ST_DATA   = 5'h08,
    ST_IGNORE = 5'h10
  } spicmd_state_t;

  // Is the array address inside the protected block
  function automatic logic spicmd_protected(input logic [1:0] bp, input logic [14:0] a);
    case (bp)
      2'h1:    spicmd_protected = (a >= PROT_QTR);
      2'h2:    spicmd_protected = (a >= PROT_HALF);
      2'h3:    spicmd_protected = 1'b1;
      default: spicmd_protected = 1'b0;
    endcase
  endfunction

  // Status byte as seen by the master
  function automatic logic [7:0] spicmd_status(input logic [1:0] bp, input logic latch);
    logic [7:0] s;
    s = ST_FIXED;
    s[ST_BP_HI] = bp[1];
    s[ST_BP_LO] = bp[0];
    s[ST_LATCH_BIT] = latch;
    spicmd_status = s;
  endfunction

  // Companion register pointer with wrap
  function automatic logic [7:0] spicmd_comp_next(input logic [7:0] a);
    spicmd_comp_next = (a == COMP_LAST) ? 8'h00 : a + 8'h01;
  endfunction
endpackage
`default_nettype wire

/* File: verilog/spicmd_sync.sv */
// Two-stage synchroniser for the serial pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module spicmd_sync #(
  parameter int         W       = 3,
  parameter logic [2:0] RST_VAL = 3'h0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST_VAL[W-1:0];
      dout <= RST_VAL[W-1:0];
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/spicmd_store.sv */
// Nonvolatile array and block-protect bits of the memory.
// Assumes one write per clk; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module spicmd_store #(
  parameter int         AW      = 15,
  parameter logic [1:0] BP_INIT = 2'h0
) (
  // Clock
  input  wire logic          clk,
  // Array port
  input  wire logic          mem_we,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [7:0]    mem_wdata,
  output logic      [7:0]    mem_rdata,
  // Block-protect bits
  input  wire logic          bp_we,
  input  wire logic [1:0]    bp_wdata,
  output logic      [1:0]    bp
);
  logic [7:0] cells [0:(1<<AW)-1];
  logic [1:0] bp_q = BP_INIT;

  // Content survives reset, as nonvolatile cells do
  assign bp = bp_q;

  // Array read
  assign mem_rdata = cells[mem_addr];

  // Byte committed the cycle it arrives
  always_ff @(posedge clk) begin
    if (mem_we) begin
      cells[mem_addr] <= mem_wdata;
    end
  end

  // Protect bits update
  always_ff @(posedge clk) begin
    if (bp_we) begin
      bp_q <= bp_wdata;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/spicmd_engine.sv */
// SPI slave command engine of a serial memory and companion.
// Assumes clk at least 8x the serial clock; pins are asynchronous.
// Operation
// [R1] Decode set-latch 06h and clear-latch 04h
// [R2] Decode status read 05h, status write 01h
// [R3] Decode array read 03h, array write 02h
// [R4] Decode companion read 13h, write 12h
// [R5] Write latch cleared after reset
// [R6] Only set-latch opcode sets the latch
// [R7] Latch clears when write-type command ends
// [R8] Master sends set-latch before each write
// [R9] Status bits 0,4,5,7 zero, bit6 one
// [R10] Bit1 latch, bits 2-3 protect select
// [R11] Protect bits kept in nonvolatile storage
// [R12] Protect select picks protected array range
// [R13] Status read shifts out status byte
// [R14] Status write loads protect bits if enabled
// [R15] Companion read: address byte, wrap 1Dh
// [R16] Companion write: address byte, wrap 1Dh
// [R17] Two-byte array address, top bit ignored
// [R18] Write burst stores, increments, rolls over
// [R19] Protected address stops burst, drops bytes
// [R20] Byte committed on its eighth bit
// [R21] Read drives MSB first, increments, rolls
// [R22] Chip select rise ends read, tristates
// [R23] Clock level at select picks mode
// [R24] Sample on rise, shift out on fall
// [R25] Unknown opcode ignored until next select
// [R26] Master waits power-up delay first
// [R27] Partial opcode discarded, nothing changes
`timescale 1ns/1ps
`default_nettype none
module spicmd_engine (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe_n,
  output logic            spi_mode3,
  // Companion register port
  output logic      [7:0] comp_addr,
  output logic      [7:0] comp_wdata,
  output logic            comp_wr,
  input  wire logic [7:0] comp_rdata
);
  import spicmd_pkg::*;

  spicmd_state_t st;
  spicmd_state_t next_st;
  logic          cs_s;
  logic          sck_s;
  logic          si_s;
  logic          cs_d;
  logic          sck_d;
  logic [2:0]    bit_cnt;
  logic [7:0]    rx_shift;
  logic [7:0]    tx_shift;
  logic [7:0]    cmd;
  logic          cmd_ok;
  logic          write_latch_flag;
  logic          latch_op;
  logic          addr_idx;
  logic          halted;
  logic [14:0]   mem_addr;
  logic [7:0]    mem_rdata;
  logic [1:0]    bp;

  // Pin synchroniser, chip select idles high
  spicmd_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({cs_n, sck, si}),
    .dout  ({cs_s, sck_s, si_s})
  );

  // Edge history of the synchronised pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
    end
  end

  // Edge and decode terms
  wire        cs_fall   = !cs_s && cs_d;
  wire        cs_rise   = cs_s && !cs_d;
  wire        sck_rise  = !cs_s && sck_s && !sck_d; // see [R24]
  wire        sck_fall  = !cs_s && !sck_s && sck_d; // see [R24]
  wire        byte_done = sck_rise && (bit_cnt == 3'h7);
  wire [7:0]  next_rx   = {rx_shift[6:0], si_s};
  wire        opc_done  = (st == ST_OPC) && byte_done;
  wire        data_done = (st == ST_DATA) && byte_done;
  wire        opc_set   = opc_done && (next_rx == OP_SET_WL);
  wire        is_comp   = (cmd == OP_COMP_RD) || (cmd == OP_COMP_WR);
  wire        is_read   = (cmd == OP_STAT_RD) || (cmd == OP_MEM_RD) || (cmd == OP_COMP_RD);
  wire        clr_end   = cmd_ok && ((cmd == OP_CLR_WL) || (cmd == OP_STAT_WR) ||
                                     (cmd == OP_MEM_WR) || (cmd == OP_COMP_WR)); // see [R7]
  wire        prot      = spicmd_protected(bp, mem_addr); // see [R12]
  wire [7:0]  status    = spicmd_status(bp, write_latch_flag); // see [R9] see [R10]
  wire        mem_we    = data_done && (cmd == OP_MEM_WR) && latch_op && !halted && !prot; // see [R19] see [R20]
  wire        bp_we     = data_done && (cmd == OP_STAT_WR) && latch_op; // see [R14]
  wire        comp_hit  = data_done && (cmd == OP_COMP_WR) && latch_op; // see [R16]
  wire        tx_load   = (st == ST_DATA) && is_read && sck_fall && (bit_cnt == 3'h0);
  wire [7:0]  tx_src    = (cmd == OP_MEM_RD) ? mem_rdata :
                          (cmd == OP_COMP_RD) ? comp_rdata : status; // see [R13] see [R15]

  // Array and protect storage
  spicmd_store #(
    .AW      (MEM_AW),
    .BP_INIT (BP_FACTORY)
  ) u_store (
    .clk       (clk),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (next_rx),
    .mem_rdata (mem_rdata),
    .bp_we     (bp_we),
    .bp_wdata  (next_rx[ST_BP_HI:ST_BP_LO]),
    .bp        (bp)
  ); // see [R11]

  // Frame sequencing
  always_comb begin
    next_st = st;
    if (cs_s) begin
      next_st = ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: begin
          if (cs_fall) next_st = ST_OPC;
        end
        ST_OPC: begin
          if (byte_done) begin
            case (next_rx)
              OP_STAT_RD, OP_STAT_WR: next_st = ST_DATA; // see [R2]
              OP_MEM_RD, OP_MEM_WR:   next_st = ST_ADDR; // see [R3]
              OP_COMP_RD, OP_COMP_WR: next_st = ST_ADDR; // see [R4]
              OP_SET_WL, OP_CLR_WL:   next_st = ST_IGNORE; // see [R1]
              default:                next_st = ST_IGNORE; // see [R25]
            endcase
          end
        end
        ST_ADDR: begin
          if (byte_done && (is_comp || addr_idx)) next_st = ST_DATA;
        end
        ST_DATA:   next_st = ST_DATA;
        ST_IGNORE: next_st = ST_IGNORE;
        default:   next_st = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) st <= ST_IDLE;
    else        st <= next_st;
  end

  // Bit counter and receive shifter
  always_ff @(posedge clk) begin
    if (!rst_n || st == ST_IDLE) begin
      bit_cnt  <= 3'h0;
      rx_shift <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      rx_shift <= next_rx;
    end
  end

  // Command capture; a cut opcode never sets cmd_ok
  always_ff @(posedge clk) begin
    if (!rst_n || st == ST_IDLE) begin
      cmd    <= 8'h00;
      cmd_ok <= 1'b0; // see [R27]
      latch_op <= 1'b0;
    end else if (opc_done) begin
      cmd    <= next_rx;
      cmd_ok <= 1'b1;
      latch_op <= write_latch_flag; // see [R8]
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (!rst_n)                  write_latch_flag <= LATCH_RST; // see [R5]
    else if (opc_set)            write_latch_flag <= 1'b1; // see [R6]
    else if (cs_rise && clr_end) write_latch_flag <= 1'b0; // see [R7]
  end

  // Clock mode caught at select
  always_ff @(posedge clk) begin
    if (!rst_n)       spi_mode3 <= 1'b0;
    else if (cs_fall) spi_mode3 <= sck_s; // see [R23]
  end

  // Array address: load, burst increment, halt on protect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr <= 15'h0000;
      addr_idx <= 1'b0;
      halted   <= 1'b0;
    end else if (st == ST_IDLE) begin
      addr_idx <= 1'b0;
      halted   <= 1'b0;
    end else if (st == ST_ADDR && byte_done && !is_comp) begin
      addr_idx <= 1'b1;
      if (!addr_idx) mem_addr[14:8] <= next_rx[6:0]; // see [R17]
      else           mem_addr[7:0]  <= next_rx;
    end else if (mem_we || (tx_load && cmd == OP_MEM_RD)) begin
      mem_addr <= mem_addr + 15'h0001; // see [R18] see [R21]
    end else if (data_done && cmd == OP_MEM_WR && prot) begin
      halted <= 1'b1; // see [R19]
    end
  end

  // Companion pointer and write strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comp_addr  <= 8'h00;
      comp_wdata <= 8'h00;
      comp_wr    <= 1'b0;
    end else begin
      comp_wr <= comp_hit;
      if (st == ST_ADDR && byte_done && is_comp) begin
        comp_addr <= next_rx;
      end else if (comp_hit) begin
        comp_wdata <= next_rx;
      end else if (comp_wr || (tx_load && cmd == OP_COMP_RD)) begin
        comp_addr <= spicmd_comp_next(comp_addr); // see [R15] see [R16]
      end
    end
  end

  // Serial output, changed only on falling clock
  always_ff @(posedge clk) begin
    if (!rst_n || st != ST_DATA) begin
      so       <= 1'b0;
      so_oe_n  <= 1'b1; // see [R22] see [R25]
      tx_shift <= 8'h00;
    end else if (tx_load) begin
      so       <= tx_src[7]; // see [R21]
      so_oe_n  <= 1'b0;
      tx_shift <= {tx_src[6:0], 1'b0};
    end else if (sck_fall && is_read) begin
      so       <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_latch_reset;
    $rose(rst_n) |-> !write_latch_flag;
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("latch set after reset"); // see [R5]

  property p_latch_only_set;
    $rose(write_latch_flag) |-> $past(opc_set);
  endproperty
  a_latch_only_set: assert property (p_latch_only_set) else $error("latch set without opcode"); // see [R6]

  property p_latch_clear;
    cs_rise && clr_end && !opc_set |=> !write_latch_flag;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared at end"); // see [R7]

  property p_status_fixed;
    status[7:4] == 4'h4 && !status[0] && status[1] == write_latch_flag && status[3:2] == bp;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status layout wrong"); // see [R9]

  property p_no_prot_write;
    mem_we |-> !spicmd_protected(bp, mem_addr) && latch_op;
  endproperty
  a_no_prot_write: assert property (p_no_prot_write) else $error("write into protected or disabled"); // see [R19]

  property p_burst_inc;
    mem_we |=> mem_addr == $past(mem_addr) + 15'h0001;
  endproperty
  a_burst_inc: assert property (p_burst_inc) else $error("array address not incremented"); // see [R18]

  property p_read_tristate;
    cs_rise |=> ##1 so_oe_n;
  endproperty
  a_read_tristate: assert property (p_read_tristate) else $error("output still driven"); // see [R22]

  property p_ignore_quiet;
    st == ST_IGNORE |-> so_oe_n && !mem_we && !bp_we && !comp_hit;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("activity after unknown opcode"); // see [R25]

  property p_comp_wrap;
    comp_wr && comp_addr == COMP_LAST |=> comp_addr == 8'h00;
  endproperty
  a_comp_wrap: assert property (p_comp_wrap) else $error("companion pointer did not wrap"); // see [R16]

  property p_cut_opcode;
    cs_rise && !cmd_ok |=> write_latch_flag == $past(write_latch_flag);
  endproperty
  a_cut_opcode: assert property (p_cut_opcode) else $error("partial opcode changed latch"); // see [R27]

  property p_so_on_fall;
    !so_oe_n && $changed(so) |-> $past(sck_fall);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output changed off falling edge"); // see [R24]

  c_array_write: cover property (mem_we);
  c_array_read:  cover property (tx_load && cmd == OP_MEM_RD);
  c_prot_halt:   cover property ($rose(halted));
  c_comp_write:  cover property (comp_wr);
endmodule
`default_nettype wire

/* File: dv/spicmd_master.sv */
// SPI bus master model for the command engine.
// Assumes clk is the bench clock; sck half period is 4 clk.
`timescale 1ns/1ps
`default_nettype none
module spicmd_master (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic mode3;
  logic oe_seen;
  // A released line shows the inverse of its last level
  wire  miso = so ^ so_oe_n;

  // Idle, deselected, until the bench opens the first frame
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3 = 1'b0;
    oe_seen = 1'b0;
  end

  // One chip select frame of nb bits, MSB first; rx collects SO bytes
  task automatic frame(input logic [7:0] tx[$], input int nb, output logic [7:0] rx[$]);
    logic [7:0] b;
    b = 8'h00;
    rx = {};
    oe_seen = 1'b0;
    @(posedge clk);
    sck <= mode3;
    repeat (2) @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      sck <= 1'b0;
      si <= tx[i / 8][7 - i % 8];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      b = {b[6:0], miso};
      oe_seen = oe_seen | !so_oe_n;
      if (i % 8 == 7) rx.push_back(b);
    end
    sck <= mode3;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/spi_memory_command_slave_tb.sv */
// Self-checking bench of the command engine against a queue model.
// Assumes spicmd_pkg and the engine are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module spi_memory_command_slave_tb;
  import spicmd_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  wire        cs_n, sck, si, so, so_oe_n, spi_mode3, comp_wr;
  wire  [7:0] comp_addr, comp_wdata, comp_rdata;
  logic [7:0] creg [0:29];
  logic [7:0] ec [0:29];
  logic [7:0] mem [int];
  logic [15:0] cq[$];
  logic       latch_exp = 1'b0;
  logic [1:0] bp = 2'h0;
  logic [31:0] seed = 32'd85;
  int         n_errors = 0;
  int         samples_checked = 0;

  // Clock
  always #20 clk = ~clk;

  // Companion registers: read at the pointer, log every write
  assign comp_rdata = (comp_addr <= 8'h1d) ? creg[comp_addr[4:0]] : 8'h00;
  always @(posedge clk) begin
    if (comp_wr) begin
      creg[comp_addr[4:0]] <= comp_wdata;
      cq.push_back({comp_addr, comp_wdata});
    end
  end

  spicmd_engine u_spicmd_engine (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe_n(so_oe_n), .spi_mode3(spi_mode3), .comp_addr(comp_addr), .comp_wdata(comp_wdata),
    .comp_wr(comp_wr), .comp_rdata(comp_rdata));
  spicmd_master u_spicmd_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic bit prot(input int p);
    return bp == 2'h3 || (bp == 2'h2 && p >= 16384) || (bp == 2'h1 && p >= 24576);
  endfunction

  // Run one frame, check enable and mode, return the reply bytes
  task automatic cmd(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
    int n;
    n = tx.size();
    repeat (nrx) tx.push_back(rnd());
    u_spicmd_master.frame(tx, 8 * (n + nrx), rx);
    `CHK("oe_seen", nrx > 0, u_spicmd_master.oe_seen)
    `CHK("oe_idle", 1'b1, so_oe_n)
    `CHK("mode", u_spicmd_master.mode3, spi_mode3)
    rx = rx[n:$];
    u_spicmd_master.mode3 = ~u_spicmd_master.mode3;
  endtask

  task automatic set_latch();
    logic [7:0] rx[$];
    cmd({OP_SET_WL}, 0, rx);
    latch_exp = 1'b1;
  endtask

  task automatic stat();
    logic [7:0] rx[$];
    cmd({OP_STAT_RD}, 1, rx);
    `CHK("status", {4'h4, bp, latch_exp, 1'b0}, rx[0])
  endtask

  task automatic stat_write(input logic [7:0] d);
    logic [7:0] rx[$];
    set_latch();
    cmd({OP_STAT_WR, d}, 0, rx);
    bp = d[3:2];
    latch_exp = 1'b0;
  endtask

  task automatic mwrite(input logic [15:0] a, input int n, input bit en);
    logic [7:0] rx[$];
    logic [7:0] tx[$];
    int p;
    bit stop;
    p = a[14:0];
    stop = 0;
    tx = {OP_MEM_WR, a[15:8], a[7:0]};
    if (en) set_latch();
    for (int k = 0; k < n; k++) begin
      tx.push_back(rnd());
      if (prot(p)) stop = 1;
      if (en && !stop) begin
        mem[p] = tx[k + 3];
        p = (p + 1) % 32768;
      end
    end
    cmd(tx, 0, rx);
    latch_exp = 1'b0;
  endtask

  task automatic mread(input logic [15:0] a, input int n);
    logic [7:0] rx[$];
    cmd({OP_MEM_RD, a[15:8], a[7:0]}, n, rx);
    for (int k = 0; k < n; k++) `CHK("mem", mem[(a[14:0] + k) % 32768], rx[k])
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog over the whole run
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [7:0] tx[$], rx[$];
    logic [15:0] a;
    for (int i = 0; i < 30; i++) begin
      creg[i] = rnd();
      ec[i] = creg[i];
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    stat(); // Latch clear after power-up
    set_latch();
    stat();
    cmd({OP_CLR_WL}, 0, rx);
    latch_exp = 1'b0;
    stat();
    stat_write(8'hff); // Latch bit in data has no effect
    stat();
    // Every protect setting against burst writes across range edges
    for (int b = 0; b < 4; b++) begin
      stat_write(8'(b * 4));
      stat();
      for (int s = 1; s < 4; s++) begin
        a = 16'(s * 8192 + 8191 + (s % 2) * 32768);
        mwrite(a, 2, 1);
        mread(a, 2);
      end
      mwrite(16'h0000, 1, 0); // Refused without the latch
      mread(16'h0000, 1);
    end
    stat_write(8'h00);
    // Companion write burst across the pointer wrap
    set_latch();
    tx = {OP_COMP_WR, 8'h1c, rnd(), rnd(), rnd()};
    cmd(tx, 0, rx);
    latch_exp = 1'b0;
    for (int k = 0; k < 3; k++) begin
      ec[(28 + k) % 30] = tx[k + 2];
      `CHK("comp_wr", {8'((28 + k) % 30), tx[k + 2]}, cq[k])
    end
    cq.delete();
    cmd({OP_COMP_WR, 8'h05, rnd()}, 0, rx);
    `CHK("comp_none", 0, cq.size())
    cmd({OP_COMP_RD, 8'h1c}, 3, rx);
    for (int k = 0; k < 3; k++) `CHK("comp_rd", ec[(28 + k) % 30], rx[k])
    // Unknown opcode hides a set-latch byte
    cmd({8'ha5, OP_SET_WL, rnd()}, 0, rx);
    stat();
    // Partial clear-latch opcode is dropped
    set_latch();
    u_spicmd_master.frame({OP_CLR_WL}, 5, rx);
    stat();
    // Reset mid-run keeps protect bits, clears the latch
    stat_write(8'h08);
    set_latch();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    latch_exp = 1'b0;
    stat();
    report_and_stop();
  end
endmodule
`default_nettype wire
